// [rtl/jesd_link_pkg.sv]
/*
  Constants for the transmit link parameter block: register offsets, field
  positions, reset values and fixed link parameters.
  Assumes an 8-bit register port with 8-bit offsets.
*/
// Function
// - 16-bit sample, 11 data bits, two spare.
// - Tail bits zero, or pseudorandom when enabled.
// - Control-bit selection replaces one or two tails.
// - Tail value setting applied to spare bits.
// - IDs sent in alignment sequence, readable.
// - Lane, device and bank identifier widths.
// - K minus one stored, K defaults 32.
// - Scrambling default on, active in data phase only.
// - Alignment option: normal, none or repeat.
// - N and N-prime read as minus one.
// - Control words per frame read zero.
// - Derived L, F, M, S, HD readable.
// - Per-lane checksum, sent and readable.
// - Checksum is modulo 256 field sum.
// - Lane checksums at two read offsets.
// - Eleven configuration octets packed per layout.
// - Polarity bit inverts lane sample words, not configuration octets.
// - Offset binary or twos complement select.
// - Remap converters and lanes to physical lanes.
// - Clearing hold bit releases link, starts sync.
// - Hold bit set keeps link in reset.
// - Quick configuration selects converters and lanes.
// - Second multiframe carries fourteen configuration octets.
package jesd_link_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] A_TAIL_FMT  = 8'h14;
  localparam logic [7:0] A_SYNC_OPT  = 8'h3A;
  localparam logic [7:0] A_QUICK_CFG = 8'h5E;
  localparam logic [7:0] A_LINK_CTRL = 8'h5F;
  localparam logic [7:0] A_POLARITY  = 8'h60;
  localparam logic [7:0] A_DEV_ID    = 8'h64;
  localparam logic [7:0] A_BANK_ID   = 8'h65;
  localparam logic [7:0] A_LANE0_ID  = 8'h67;
  localparam logic [7:0] A_LANE1_ID  = 8'h68;
  localparam logic [7:0] A_SCR_LANES = 8'h6E;
  localparam logic [7:0] A_OCTETS    = 8'h6F;
  localparam logic [7:0] A_FRAMES    = 8'h70;
  localparam logic [7:0] A_CONV_CNT  = 8'h71;
  localparam logic [7:0] A_CTRL_RES  = 8'h72;
  localparam logic [7:0] A_SMP_BITS  = 8'h73;
  localparam logic [7:0] A_SMP_CONV  = 8'h74;
  localparam logic [7:0] A_DENS_CW   = 8'h75;
  localparam logic [7:0] A_FCHK0     = 8'h78;
  localparam logic [7:0] A_FCHK1     = 8'h79;
  localparam logic [7:0] A_REMAP_A   = 8'h82;
  localparam logic [7:0] A_REMAP_B   = 8'h83;
  // ==========================================================
  // Field positions
  localparam int HOLD_BIT      = 0;
  localparam int ILAS_LSB      = 2;
  localparam int TAIL_RAND_BIT = 6;
  localparam int POL_INV_BIT   = 1;
  localparam int SCR_BIT       = 7;
  localparam int CS_LSB        = 6;
  localparam int TAIL_VAL_LSB  = 5;
  localparam int REMAP_STRIDE  = 4;
  localparam int DATA_LSB      = 5;
  localparam int SPARE_LSB     = 3;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_TAIL_FMT  = 8'h00;
  localparam logic [7:0] RST_QUICK_CFG = 8'h22;
  localparam logic [7:0] RST_LINK_CTRL = 8'h00;
  localparam logic [4:0] RST_LANE1_ID  = 5'h01;
  localparam logic [7:0] RST_FRAMES    = 8'h1F;
  localparam logic [7:0] RST_REMAP     = 8'h10;
  // ==========================================================
  // Fixed parameters and codes
  localparam logic [4:0] N_M1        = 5'h0A;
  localparam logic [4:0] NP_M1       = 5'h0F;
  localparam logic [4:0] CF_VAL      = 5'h00;
  localparam logic [2:0] SUBCLASS    = 3'h1;
  localparam logic [2:0] JESDV       = 3'h1;
  localparam logic [7:0] QC_1C1L     = 8'h11;
  localparam logic [7:0] QC_1C2L     = 8'h12;
  localparam logic [7:0] QC_2C1L     = 8'h21;
  localparam logic [1:0] ILAS_NORMAL = 2'h0;
  localparam logic [1:0] ILAS_NONE   = 2'h1;
  localparam logic [1:0] ILAS_LAST_MF = 2'h3;
  localparam logic [1:0] FMT_TWOS    = 2'h1;
  typedef enum logic [3:0] {
    ST_HOLD = 4'h1,
    ST_CGS  = 4'h2,
    ST_ILAS = 4'h4,
    ST_DATA = 4'h8
  } phase_t;
endpackage

// [rtl/lane_cfg_octets.sv]
/*
  Configuration octets and checksum for one lane.
  Assumes field values are already in the minus-one notation where the link uses it.
*/
`timescale 1ns/1ps
`default_nettype none
module lane_cfg_octets (
  // Link fields
  input  wire logic [7:0] did_i,
  input  wire logic [3:0] bid_i,
  input  wire logic [4:0] lid_i,
  input  wire logic       scr_i,
  input  wire logic [4:0] l_m1_i,
  input  wire logic [7:0] f_m1_i,
  input  wire logic [4:0] k_m1_i,
  input  wire logic [7:0] m_m1_i,
  input  wire logic [1:0] cs_i,
  input  wire logic [4:0] s_m1_i,
  input  wire logic       hd_i,
  // Octet select and results
  input  wire logic [3:0] idx_i,
  output logic      [7:0] octet_o,
  output logic      [7:0] fchk_o
);
  import jesd_link_pkg::*;
  // ==========================================================
  // Field sum, before packing
  assign fchk_o = did_i + 8'(bid_i) + 8'(lid_i) + 8'(scr_i) + 8'(l_m1_i)
                + f_m1_i + 8'(k_m1_i) + m_m1_i + 8'(cs_i) + 8'(N_M1)
                + 8'(SUBCLASS) + 8'(NP_M1) + 8'(JESDV) + 8'(s_m1_i)
                + 8'(hd_i) + 8'(CF_VAL);
  // ==========================================================
  // Octet packing
  always_comb begin
    case (idx_i)
      4'h0:    octet_o = did_i;
      4'h1:    octet_o = {4'h0, bid_i};
      4'h2:    octet_o = {3'h0, lid_i};
      4'h3:    octet_o = {scr_i, 2'h0, l_m1_i};
      4'h4:    octet_o = f_m1_i;
      4'h5:    octet_o = {3'h0, k_m1_i};
      4'h6:    octet_o = m_m1_i;
      4'h7:    octet_o = {cs_i, 1'b0, N_M1};
      4'h8:    octet_o = {SUBCLASS, NP_M1};
      4'h9:    octet_o = {JESDV, s_m1_i};
      4'hA:    octet_o = {hd_i, 2'h0, CF_VAL};
      4'hD:    octet_o = fchk_o;
      default: octet_o = 8'h00;
    endcase
  end
endmodule
`default_nettype wire

// [rtl/jesd_tx_link_cfg.sv]
/*
  Transmit link parameter registers, derived values, link phase control and
  per-lane sample formatting for a two-converter, two-lane transmitter.
  Assumes a serializer that consumes lane words, sends the octets selected by
  cfg_idx_i during alignment, and pulses frame_tick_i once per frame.
*/
`timescale 1ns/1ps
`default_nettype none
module jesd_tx_link_cfg #(
  parameter int LANES = 2
) (
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  // Register port
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  input  wire logic [7:0]           reg_addr_i,
  input  wire logic [7:0]           reg_wdata_i,
  output logic      [7:0]           reg_rdata_o,
  // Link control
  input  wire logic                 sync_n_i,
  input  wire logic                 frame_tick_i,
  output logic                      link_hold_o,
  output jesd_link_pkg::phase_t     phase_o,
  output logic      [1:0]           ilas_mf_o,
  output logic      [4:0]           ilas_frame_o,
  output logic                      scramble_on_o,
  // Converter samples
  input  wire logic                 sample_valid_i,
  input  wire logic [10:0]          adc0_i,
  input  wire logic [10:0]          adc1_i,
  input  wire logic [1:0][1:0]      ctrl_i,
  // Lane words
  output logic                      lane_valid_o,
  output logic [LANES-1:0][15:0]    lane_data_o,
  // Configuration octets
  input  wire logic [3:0]           cfg_idx_i,
  output logic [LANES-1:0][7:0]     cfg_octet_o
);
  import jesd_link_pkg::*;
  // ==========================================================
  // Register storage
  logic [7:0]  tail_fmt_ff;
  logic [7:0]  sync_opt_ff;
  logic [7:0]  quick_cfg_ff;
  logic [7:0]  link_ctrl_ff;
  logic        pol_ff;
  logic [7:0]  did_ff;
  logic [3:0]  bid_ff;
  logic [4:0]  lid0_ff;
  logic [4:0]  lid1_ff;
  logic        scr_ff;
  logic [7:0]  k_m1_ff;
  logic [1:0]  cs_ff;
  logic [7:0]  remap_a_ff;
  logic [7:0]  remap_b_ff;
  logic [7:0]  rdata_ff;
  logic [7:0]  nxt_rdata;
  logic [15:0] lfsr_ff;
  phase_t      phase_ff;
  phase_t      nxt_phase;
  logic [4:0]  frame_cnt_ff;
  logic [1:0]  mf_cnt_ff;
  logic        lane_valid_ff;
  logic [LANES-1:0][15:0] lane_ff;
  logic [LANES-1:0][7:0]  octet_ff;
  logic [LANES-1:0][7:0]  octet_w;
  logic [LANES-1:0][7:0]  fchk_w;
  logic [1:0][15:0]       slot_word;
  // ==========================================================
  // Write decode
  wire wr_tail  = reg_wr_i && (reg_addr_i == A_TAIL_FMT);
  wire wr_sync  = reg_wr_i && (reg_addr_i == A_SYNC_OPT);
  wire wr_qc    = reg_wr_i && (reg_addr_i == A_QUICK_CFG);
  wire wr_link  = reg_wr_i && (reg_addr_i == A_LINK_CTRL);
  wire wr_pol   = reg_wr_i && (reg_addr_i == A_POLARITY);
  wire wr_did   = reg_wr_i && (reg_addr_i == A_DEV_ID);
  wire wr_bid   = reg_wr_i && (reg_addr_i == A_BANK_ID);
  wire wr_lid0  = reg_wr_i && (reg_addr_i == A_LANE0_ID);
  wire wr_lid1  = reg_wr_i && (reg_addr_i == A_LANE1_ID);
  wire wr_scr   = reg_wr_i && (reg_addr_i == A_SCR_LANES);
  wire wr_k     = reg_wr_i && (reg_addr_i == A_FRAMES);
  wire wr_cs    = reg_wr_i && (reg_addr_i == A_CTRL_RES);
  wire wr_rma   = reg_wr_i && (reg_addr_i == A_REMAP_A);
  wire wr_rmb   = reg_wr_i && (reg_addr_i == A_REMAP_B);
  // ==========================================================
  // Control fields
  wire       hold      = link_ctrl_ff[HOLD_BIT];
  wire [1:0] ilas_mode = link_ctrl_ff[ILAS_LSB +: 2];
  wire       tail_rand = link_ctrl_ff[TAIL_RAND_BIT];
  wire [1:0] tail_val  = tail_fmt_ff[TAIL_VAL_LSB +: 2];
  wire       twos      = (tail_fmt_ff[1:0] == FMT_TWOS);
  // ==========================================================
  // Derived values from quick configuration
  wire       qc_11 = (quick_cfg_ff == QC_1C1L);
  wire       qc_12 = (quick_cfg_ff == QC_1C2L);
  wire       qc_21 = (quick_cfg_ff == QC_2C1L);
  wire       l_m1  = ~(qc_11 | qc_21);
  wire       m_m1  = ~(qc_11 | qc_12);
  wire [7:0] f_m1  = qc_12 ? 8'h00 : (qc_21 ? 8'h03 : 8'h01);
  wire [4:0] s_m1  = 5'h00;
  wire       hd    = qc_12;
  // ==========================================================
  // Register writes
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tail_fmt_ff  <= RST_TAIL_FMT;
      sync_opt_ff  <= 8'h00;
      quick_cfg_ff <= RST_QUICK_CFG;
      link_ctrl_ff <= RST_LINK_CTRL;
      pol_ff       <= 1'b0;
      did_ff       <= 8'h00;
      bid_ff       <= 4'h0;
      lid0_ff      <= 5'h00;
      lid1_ff      <= RST_LANE1_ID;
      scr_ff       <= 1'b1;
      k_m1_ff      <= RST_FRAMES;
      cs_ff        <= 2'h0;
      remap_a_ff   <= RST_REMAP;
      remap_b_ff   <= RST_REMAP;
    end else begin
      if (wr_tail) tail_fmt_ff  <= reg_wdata_i;
      if (wr_sync) sync_opt_ff  <= reg_wdata_i;
      if (wr_qc)   quick_cfg_ff <= reg_wdata_i;
      if (wr_link) link_ctrl_ff <= reg_wdata_i;
      if (wr_pol)  pol_ff       <= reg_wdata_i[POL_INV_BIT];
      if (wr_did)  did_ff       <= reg_wdata_i;
      if (wr_bid)  bid_ff       <= reg_wdata_i[3:0];
      if (wr_lid0) lid0_ff      <= reg_wdata_i[4:0];
      if (wr_lid1) lid1_ff      <= reg_wdata_i[4:0];
      if (wr_scr)  scr_ff       <= reg_wdata_i[SCR_BIT];
      if (wr_k)    k_m1_ff      <= reg_wdata_i;
      if (wr_cs)   cs_ff        <= reg_wdata_i[CS_LSB +: 2];
      if (wr_rma)  remap_a_ff   <= reg_wdata_i;
      if (wr_rmb)  remap_b_ff   <= reg_wdata_i;
    end
  end
  // ==========================================================
  // Read mux
  always_comb begin
    case (reg_addr_i)
      A_TAIL_FMT:  nxt_rdata = tail_fmt_ff;
      A_SYNC_OPT:  nxt_rdata = sync_opt_ff;
      A_QUICK_CFG: nxt_rdata = quick_cfg_ff;
      A_LINK_CTRL: nxt_rdata = link_ctrl_ff;
      A_POLARITY:  nxt_rdata = {6'h00, pol_ff, 1'b0};
      A_DEV_ID:    nxt_rdata = did_ff;
      A_BANK_ID:   nxt_rdata = {4'h0, bid_ff};
      A_LANE0_ID:  nxt_rdata = {3'h0, lid0_ff};
      A_LANE1_ID:  nxt_rdata = {3'h0, lid1_ff};
      A_SCR_LANES: nxt_rdata = {scr_ff, 6'h00, l_m1};
      A_OCTETS:    nxt_rdata = f_m1;
      A_FRAMES:    nxt_rdata = k_m1_ff;
      A_CONV_CNT:  nxt_rdata = {7'h00, m_m1};
      A_CTRL_RES:  nxt_rdata = {cs_ff, 2'h0, N_M1[3:0]};
      A_SMP_BITS:  nxt_rdata = {SUBCLASS, 1'b0, NP_M1[3:0]};
      A_SMP_CONV:  nxt_rdata = {JESDV, s_m1};
      A_DENS_CW:   nxt_rdata = {hd, 2'h0, CF_VAL};
      A_FCHK0:     nxt_rdata = fchk_w[0];
      A_FCHK1:     nxt_rdata = fchk_w[LANES-1];
      A_REMAP_A:   nxt_rdata = remap_a_ff;
      A_REMAP_B:   nxt_rdata = remap_b_ff;
      default:     nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign reg_rdata_o = rdata_ff;
  // ==========================================================
  // Link phase control
  wire k_end  = (frame_cnt_ff == k_m1_ff[4:0]);
  wire mf_end = frame_tick_i && k_end && (mf_cnt_ff == ILAS_LAST_MF);

  always_comb begin
    case (phase_ff)
      ST_HOLD: nxt_phase = ST_CGS;
      ST_CGS:  nxt_phase = !sync_n_i ? ST_CGS :
                           (ilas_mode == ILAS_NONE) ? ST_DATA : ST_ILAS;
      ST_ILAS: nxt_phase = !sync_n_i ? ST_CGS :
                           (mf_end && ilas_mode == ILAS_NORMAL) ? ST_DATA : ST_ILAS;
      ST_DATA: nxt_phase = !sync_n_i ? ST_CGS : ST_DATA;
      default: nxt_phase = ST_HOLD;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || hold) begin
      phase_ff <= ST_HOLD;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || phase_ff != ST_ILAS) begin
      frame_cnt_ff <= 5'h00;
      mf_cnt_ff    <= 2'h0;
    end else if (frame_tick_i) begin
      frame_cnt_ff <= k_end ? 5'h00 : frame_cnt_ff + 5'h01;
      mf_cnt_ff    <= k_end ? mf_cnt_ff + 2'h1 : mf_cnt_ff;
    end
  end

  assign link_hold_o   = hold;
  assign phase_o       = phase_ff;
  assign ilas_mf_o     = mf_cnt_ff;
  assign ilas_frame_o  = frame_cnt_ff;
  assign scramble_on_o = scr_ff && (phase_ff == ST_DATA);
  // ==========================================================
  // Tail pseudorandom source
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      lfsr_ff <= 16'hACE1;
    end else if (sample_valid_i) begin
      lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
    end
  end
  // ==========================================================
  // Sample slots and lanes
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_slot
      wire        sel   = remap_a_ff[g*REMAP_STRIDE];
      wire [10:0] raw   = sel ? adc1_i : adc0_i;
      wire [10:0] fmt   = twos ? {~raw[10], raw[9:0]} : raw;
      wire [1:0]  tail  = tail_rand ? lfsr_ff[2*g +: 2] : tail_val;
      wire [1:0]  ctl   = ctrl_i[sel];
      wire [1:0]  spare = (cs_ff == 2'h0) ? tail :
                          (cs_ff == 2'h1) ? {ctl[0], tail[0]} : ctl;
      assign slot_word[g] = {fmt, spare, 3'b000};
    end
    for (g = 0; g < LANES; g++) begin : g_lane
      wire lsel = remap_b_ff[g*REMAP_STRIDE];
      lane_cfg_octets u_octets (
        .did_i   (did_ff),
        .bid_i   (bid_ff),
        .lid_i   ((g == 0) ? lid0_ff : lid1_ff),
        .scr_i   (scr_ff),
        .l_m1_i  ({4'h0, l_m1}),
        .f_m1_i  (f_m1),
        .k_m1_i  (k_m1_ff[4:0]),
        .m_m1_i  ({7'h00, m_m1}),
        .cs_i    (cs_ff),
        .s_m1_i  (s_m1),
        .hd_i    (hd),
        .idx_i   (cfg_idx_i),
        .octet_o (octet_w[g]),
        .fchk_o  (fchk_w[g])
      );
      always_ff @(posedge mclk_i) begin
        if (rst_i || hold) begin
          lane_ff[g]  <= 16'h0000;
          octet_ff[g] <= 8'h00;
        end else begin
          octet_ff[g] <= octet_w[g];
          if (sample_valid_i) begin
            lane_ff[g] <= slot_word[lsel] ^ {16{pol_ff}};
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (rst_i || hold) begin
      lane_valid_ff <= 1'b0;
    end else begin
      lane_valid_ff <= sample_valid_i;
    end
  end
  assign lane_valid_o = lane_valid_ff;
  assign lane_data_o  = lane_ff;
  assign cfg_octet_o  = octet_ff;
  // ==========================================================
  // Assertions
  AST_HOLD_KEEPS_RESET: assert property (@(posedge mclk_i) disable iff (rst_i)
    hold |=> (phase_ff == ST_HOLD) && !lane_valid_o)
    else $error("Link left reset while hold set");
  AST_RELEASE_CGS: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(hold) |=> (phase_ff == ST_CGS))
    else $error("Link not released into code group sync");
  AST_SCR_ONLY_DATA: assert property (@(posedge mclk_i) disable iff (rst_i)
    (phase_ff == ST_ILAS) |-> !scramble_on_o)
    else $error("Scrambling active during alignment");
  AST_ILAS_SKIP: assert property (@(posedge mclk_i) disable iff (rst_i)
    (phase_ff == ST_CGS && sync_n_i && ilas_mode == ILAS_NONE && !hold)
      |=> (phase_ff == ST_DATA))
    else $error("Alignment sequence not skipped");
  AST_LOW_BITS_ZERO: assert property (@(posedge mclk_i) disable iff (rst_i)
    (lane_valid_o && $past(sample_valid_i) && !$past(pol_ff))
      |-> (lane_data_o[0][2:0] == 3'h0))
    else $error("Low sample bits not zero");
  AST_FIXED_N: assert property (@(posedge mclk_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == A_CTRL_RES) |=> (reg_rdata_o[3:0] == 4'hA))
    else $error("Converter resolution field wrong");
  AST_CF_ZERO: assert property (@(posedge mclk_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == A_DENS_CW) |=> (reg_rdata_o[4:0] == 5'h00))
    else $error("Control word count not zero");
  AST_FCHK_READ: assert property (@(posedge mclk_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == A_FCHK0) |=> (reg_rdata_o == $past(fchk_w[0])))
    else $error("Lane 0 checksum read mismatch");
  AST_SPLIT_LANES: assert property (@(posedge mclk_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == A_OCTETS && qc_12) |=> (reg_rdata_o == 8'h00))
    else $error("Octets per frame wrong for one converter two lanes");
  COV_ILAS_DONE: cover property (@(posedge mclk_i) disable iff (rst_i)
    (phase_ff == ST_ILAS) ##1 (phase_ff == ST_DATA));
  COV_REPEAT: cover property (@(posedge mclk_i) disable iff (rst_i)
    mf_end && (phase_ff == ST_ILAS) && ilas_mode[1]);
  COV_RAND_TAIL: cover property (@(posedge mclk_i) disable iff (rst_i)
    lane_valid_o && tail_rand && (cs_ff == 2'h0));
endmodule
`default_nettype wire

// [sim/jesd_rx_model.sv]
/*
  Receiver model: asks for code group sync, then releases it, and paces frames.
  Assumes it shares the transmitter's clock and sees its phase.
*/
`timescale 1ns/1ps
`default_nettype none
module jesd_rx_model (
  // Clock and link state
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  input  wire jesd_link_pkg::phase_t phase_i,
  input  wire logic                  resync_i,
  // Link answers
  output logic                       sync_n_o,
  output logic                       frame_tick_o
);
  import jesd_link_pkg::*;
  logic [3:0] cgs_ff;
  logic       up_w;
  // ==========================================================
  // Sync held low until code groups seen
  assign up_w = (phase_i == ST_ILAS) || (phase_i == ST_DATA) || (cgs_ff > 4'h8);
  always_ff @(posedge mclk_i) begin
    frame_tick_o <= rst_i ? 1'b0 : ~frame_tick_o;
    cgs_ff <= (rst_i || phase_i != ST_CGS) ? 4'h0 : cgs_ff + {3'h0, cgs_ff != 4'hF};
    sync_n_o <= !rst_i && !resync_i && up_w;
  end
endmodule
`default_nettype wire

// [sim/jesd204b_tx_link_param_config_bench.sv]
/*
  Self-checking bench of the link parameter block.
  Assumes the receiver model paces frames and releases sync.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin failures++; \
  $display("wrong value %s exp %h got %h", nm, ex, got); end end
module jesd204b_tx_link_param_config_bench;
  import jesd_link_pkg::*;
  logic mclk_i, rst_i, reg_wr_i, reg_rd_i, sync_n_i, frame_tick_i, resync;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
  logic link_hold_o, scramble_on_o, sample_valid_i, lane_valid_o;
  phase_t phase_o;
  logic [10:0] adc0_i, adc1_i;
  logic [1:0][1:0] ctrl_i;
  logic [1:0][15:0] lane_data_o;
  logic [3:0] cfg_idx_i;
  logic [1:0] ilas_mf;
  logic [4:0] ilas_frame;
  logic [1:0][7:0] cfg_octet_o;
  int compares, failures, ticks, scr_bad;
  logic [27:0] rows[] = '{28'h0_14_00_00, 28'h0_5E_00_22, 28'h0_5F_00_00, 28'h0_60_00_00,
    28'h0_64_00_00, 28'h0_65_00_00, 28'h0_67_00_00, 28'h0_68_00_01, 28'h0_6E_00_81,
    28'h0_6F_00_01, 28'h0_70_00_1F, 28'h0_71_00_01, 28'h0_72_00_0A, 28'h0_73_00_2F,
    28'h0_74_00_20, 28'h0_75_00_00, 28'h0_78_00_3E, 28'h0_79_00_3F, 28'h0_82_00_10,
    28'h0_83_00_10, 28'h1_01_A5_00, 28'h1_64_A5_A5, 28'h1_65_07_07, 28'h1_67_03_03,
    28'h1_71_55_01, 28'h1_6E_00_01, 28'h0_78_00_EC, 28'h1_6E_80_81, 28'h0_78_00_ED,
    28'h0_79_00_EB, 28'h1_5E_12_12, 28'h0_6F_00_00, 28'h0_75_00_80, 28'h0_71_00_00,
    28'h0_78_00_EC, 28'h1_5E_21_21, 28'h0_6F_00_03, 28'h0_6E_00_80, 28'h0_75_00_00,
    28'h1_5E_11_11, 28'h0_71_00_00, 28'h0_6E_00_80, 28'h0_6F_00_01, 28'h1_5E_22_22};
  logic [19:0] octs[] = '{20'h0_A5_A5, 20'h2_03_01, 20'h3_81_81, 20'h5_0B_0B,
    20'hB_00_00, 20'hD_D9_D7};
  jesd_tx_link_cfg dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .sync_n_i(sync_n_i), .frame_tick_i(frame_tick_i),
    .link_hold_o(link_hold_o), .phase_o(phase_o), .ilas_mf_o(ilas_mf),
    .ilas_frame_o(ilas_frame),
    .scramble_on_o(scramble_on_o), .sample_valid_i(sample_valid_i), .adc0_i(adc0_i),
    .adc1_i(adc1_i), .ctrl_i(ctrl_i), .lane_valid_o(lane_valid_o),
    .lane_data_o(lane_data_o), .cfg_idx_i(cfg_idx_i), .cfg_octet_o(cfg_octet_o));
  jesd_rx_model rx_u (.mclk_i(mclk_i), .rst_i(rst_i), .phase_i(phase_o),
    .resync_i(resync), .sync_n_o(sync_n_i), .frame_tick_o(frame_tick_i));
  // ==========================================================
  // Bus, sample and phase tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = v;
    @(negedge mclk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge mclk_i);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(negedge mclk_i);
    reg_rd_i = 1'b0;
    d = reg_rdata_o;
  endtask
  task automatic smp(input logic v, input logic [15:0] e0, input logic [15:0] e1);
    @(negedge mclk_i);
    sample_valid_i = 1'b1;
    @(negedge mclk_i);
    sample_valid_i = 1'b0;
    `CHK("lane_valid", v, lane_valid_o)
    `CHK("lane0", e0, lane_data_o[0])
    `CHK("lane1", e1, lane_data_o[1])
  endtask
  task automatic await(input phase_t p, input int lim);
    int n;
    n = 0;
    while (phase_o !== p && n < lim) begin
      @(negedge mclk_i);
      if (phase_o === ST_ILAS && frame_tick_i === 1'b1) ticks++;
      if (phase_o === ST_ILAS && scramble_on_o !== 1'b0) scr_bad++;
      n++;
    end
    `CHK("phase", p, phase_o)
  endtask
  task automatic close_out;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================================
  // Clock, watchdog and tests
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  initial begin
    #200000;
    failures++;
    close_out();
  end
  initial begin
    {rst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {3'b100, 16'h0};
    {resync, sample_valid_i, cfg_idx_i, ctrl_i} = '0;
    adc0_i = 11'h400;
    adc1_i = 11'h123;
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 1'b0;
    `CHK("rdata_rst", 8'h00, reg_rdata_o)
    `CHK("valid_rst", 1'b0, lane_valid_o)
    foreach (rows[i]) begin
      if (rows[i][24]) wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16]);
      `CHK("reg", rows[i][7:0], d)
    end
    $display("test registers done");
    wr(A_LINK_CTRL, 8'h01);
    repeat (2) @(negedge mclk_i);
    `CHK("hold", 1'b1, link_hold_o)
    `CHK("phase_hold", ST_HOLD, phase_o)
    smp(1'b0, 16'h0000, 16'h0000);
    wr(A_FRAMES, 8'h0B);
    wr(A_LINK_CTRL, 8'h00);
    ticks = 0;
    await(ST_ILAS, 60);
    await(ST_DATA, 400);
    `CHK("ilas_ticks", 48, ticks)
    `CHK("scr_in_ilas", 0, scr_bad)
    `CHK("scr_data", 1'b1, scramble_on_o)
    $display("test link phases done");
    smp(1'b1, 16'h8000, 16'h2460);
    wr(A_TAIL_FMT, 8'h60);
    smp(1'b1, 16'h8018, 16'h2478);
    wr(A_TAIL_FMT, 8'h01);
    smp(1'b1, 16'h0000, 16'hA460);
    wr(A_TAIL_FMT, 8'h00);
    wr(A_CTRL_RES, 8'h80);
    ctrl_i = {2'b01, 2'b10};
    smp(1'b1, 16'h8010, 16'h2468);
    wr(A_CTRL_RES, 8'h40);
    smp(1'b1, 16'h8000, 16'h2470);
    wr(A_CTRL_RES, 8'h00);
    wr(A_POLARITY, 8'h02);
    smp(1'b1, 16'h7FFF, 16'hDB9F);
    wr(A_POLARITY, 8'h00);
    wr(A_REMAP_B, 8'h01);
    smp(1'b1, 16'h2460, 16'h8000);
    wr(A_REMAP_A, 8'h01);
    smp(1'b1, 16'h8000, 16'h2460);
    wr(A_LINK_CTRL, 8'h40);
    @(negedge mclk_i);
    sample_valid_i = 1'b1;
    @(negedge mclk_i);
    sample_valid_i = 1'b0;
    `CHK("rand_data", 11'h400, lane_data_o[0][15:5])
    `CHK("rand_low", 3'h0, lane_data_o[0][2:0])
    $display("test samples done");
    foreach (octs[i]) begin
      @(negedge mclk_i);
      cfg_idx_i = octs[i][19:16];
      @(negedge mclk_i);
      `CHK("octet0", octs[i][15:8], cfg_octet_o[0])
      `CHK("octet1", octs[i][7:0], cfg_octet_o[1])
    end
    $display("test octets done");
    wr(A_LINK_CTRL, 8'h05);
    wr(A_LINK_CTRL, 8'h04);
    ticks = 0;
    await(ST_DATA, 100);
    `CHK("no_ilas_ticks", 0, ticks)
    wr(A_LINK_CTRL, 8'h09);
    wr(A_LINK_CTRL, 8'h08);
    ticks = 0;
    await(ST_ILAS, 60);
    repeat (60) begin
      @(negedge mclk_i);
      if (frame_tick_i === 1'b1) ticks++;
    end
    `CHK("ilas_frame", 5'((ticks - frame_tick_i) % 12), ilas_frame)
    `CHK("ilas_mf", 2'((ticks - frame_tick_i) / 12), ilas_mf)
    repeat (200) @(negedge mclk_i);
    `CHK("ilas_repeat", ST_ILAS, phase_o)
    resync = 1'b1;
    await(ST_CGS, 20);
    resync = 1'b0;
    rst_i = 1'b1;
    @(negedge mclk_i);
    rst_i = 1'b0;
    rd(A_FRAMES);
    `CHK("k_rst", 8'h1F, d)
    $display("test resync and reset done");
    close_out();
  end
endmodule
`default_nettype wire
